// file: bench/audio_clock_mode_control_tb_top.sv
// self-checking bench for the audio clock mode controller
// assumes small lock counts and a pll step every cycle
module audio_clock_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic pll; logic ms; logic aux; clock_mode_pkg::clock_mode_t mode;
   } row_t;
   logic sys_clk = 1'b0, srst = 1'b1, power_down_n = 1'b1, pll_power_enable = 1'b0;
   logic master_select = 1'b0, aux_input3_select = 1'b0, bit_clock_rate_select = 1'b0;
   logic master_clock_out_enable = 1'b0, slave_run = 1'b0, mclk_run = 1'b0;
   logic [3:0] pll_ref_select = 4'h0, rate_select = 4'h0;
   logic [1:0] mclk_out_divider = 2'h0;
   logic [5:0] bits_per_frame = 6'h20;
   logic bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe, master_clock_out;
   logic pll_locked, pll_ref_invalid, slave_bit_rate_low, p_bit, p_frame, p_en, p_mclk;
   logic bit_line, frame_line;
   clock_mode_pkg::clock_mode_t clock_mode;
   int mismatches = 0, n_tests = 0, cnt;
   row_t rows [7] = '{
      '{1'b0, 1'b0, 1'b0, clock_mode_pkg::MODE_EXT_SLAVE},
      '{1'b0, 1'b1, 1'b0, clock_mode_pkg::MODE_EXT_MASTER},
      '{1'b1, 1'b0, 1'b0, clock_mode_pkg::MODE_PLL_SLAVE},
      '{1'b1, 1'b1, 1'b0, clock_mode_pkg::MODE_PLL_MASTER},
      '{1'b1, 1'b0, 1'b1, clock_mode_pkg::MODE_EXT_SLAVE},
      '{1'b1, 1'b1, 1'b1, clock_mode_pkg::MODE_EXT_MASTER},
      '{1'b0, 1'b0, 1'b1, clock_mode_pkg::MODE_EXT_SLAVE}};
   int lock_ref [4] = '{0, 2, 4, 14};
   int lock_cyc [4] = '{40, 10, 20, 30};
   always #2.5 sys_clk = ~sys_clk;
   // pin resolution with external pull-down
   assign bit_line   = bit_clock_oe ? bit_clock_out : (p_en ? p_bit : 1'b0);
   assign frame_line = frame_clock_oe ? frame_clock_out : (p_en ? p_frame : 1'b0);
   audio_clock_mode_control #(
      .LOCK_FRAME_CYC(40), .LOCK_BIT_CYC(10), .LOCK_MASTER_CLOCK_IN_CYC(20),
      .LOCK_MASTER_CLOCK_IN_SLOW_CYC(30), .TICK_DIV(1)
   ) u_dut (
      .sys_clk(sys_clk), .srst(srst), .power_down_n(power_down_n),
      .pll_power_enable(pll_power_enable), .master_select(master_select),
      .aux_input3_select(aux_input3_select), .pll_ref_select(pll_ref_select),
      .rate_select(rate_select), .bit_clock_rate_select(bit_clock_rate_select),
      .mclk_out_divider(mclk_out_divider),
      .master_clock_out_enable(master_clock_out_enable), .master_clock_in(p_mclk),
      .bit_clock_in(bit_line), .frame_clock_in(frame_line),
      .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
      .frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
      .master_clock_out(master_clock_out), .clock_mode(clock_mode),
      .pll_locked(pll_locked), .pll_ref_invalid(pll_ref_invalid),
      .slave_bit_rate_low(slave_bit_rate_low));
   audio_port_partner u_partner (
      .sys_clk(sys_clk), .slave_run(slave_run), .mclk_run(mclk_run),
      .bits_per_frame(bits_per_frame), .bit_drive(p_bit), .frame_drive(p_frame),
      .drive_en(p_en), .mclk_drive(p_mclk));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // rising edges of one output over n cycles: 0 bit, 1 frame, 2 master clock
   task automatic rises(input int sel, input int n, output int c);
      logic prev, cur;
      c = 0;
      prev = (sel == 0) ? bit_clock_out : (sel == 1) ? frame_clock_out : master_clock_out;
      repeat (n) begin
         cyc(1);
         cur = (sel == 0) ? bit_clock_out : (sel == 1) ? frame_clock_out : master_clock_out;
         if (cur && !prev) c++;
         prev = cur;
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      wrap_up();
   end
   initial begin
      cyc(5);
      check(clock_mode, 16'h0);
      check({bit_clock_oe, frame_clock_oe, pll_locked}, 16'h0);
      srst = 1'b0;
      cyc(4);
      $display("test reset done");
      foreach (rows[i]) begin
         pll_power_enable = rows[i].pll;
         master_select = rows[i].ms;
         aux_input3_select = rows[i].aux;
         slave_run = ~rows[i].ms;
         cyc(6);
         check(clock_mode, rows[i].mode);
         check({bit_clock_oe, frame_clock_oe}, {2{rows[i].ms}});
         rises(2, 8, cnt);
         check(cnt, 0);
      end
      $display("test mode table done");
      slave_run = 1'b0;
      aux_input3_select = 1'b0;
      master_select = 1'b1;
      foreach (lock_ref[i]) begin
         pll_power_enable = 1'b0;
         pll_ref_select = lock_ref[i][3:0];
         cyc(4);
         pll_power_enable = 1'b1;
         rises(0, lock_cyc[i] - 3, cnt);
         check(cnt, 0);
         check({pll_locked, bit_clock_oe, frame_clock_out}, 16'h2);
         cyc(8);
         check(pll_locked, 1'b1);
      end
      rate_select = 4'h1;
      cyc(2);
      check(pll_locked, 1'b0);
      cyc(32);
      check(pll_locked, 1'b1);
      $display("test lock done");
      for (int b = 0; b < 2; b++) begin
         bit_clock_rate_select = b[0];
         cyc(2);
         rises(0, 1024, cnt);
         check(cnt, b ? 128 : 64);
         rises(1, 1024, cnt);
         check(cnt, 2);
      end
      master_clock_out_enable = 1'b1;
      for (int d = 0; d < 4; d++) begin
         mclk_out_divider = d[1:0];
         cyc(2);
         rises(2, 1024, cnt);
         check(cnt, 512 >> d);
      end
      $display("test master rates done");
      foreach (rows[i]) begin
         if (i < 4) begin
            pll_power_enable = 1'b0;
            pll_ref_select = (i == 0) ? 4'h1 : 4'h8 + i[3:0];
            cyc(4);
            pll_power_enable = 1'b1;
            cyc(60);
            check({pll_ref_invalid, pll_locked}, 16'h2);
         end
      end
      $display("test invalid reference done");
      pll_power_enable = 1'b0;
      mclk_run = 1'b1;
      for (int r = 0; r < 3; r++) begin
         rate_select = r[3:0];
         cyc(8);
         rises(1, 4096, cnt);
         check(cnt, 4 >> r);
         rises(2, 64, cnt);
         check(cnt, 0);
      end
      $display("test external master done");
      power_down_n = 1'b0;
      cyc(10);
      check({clock_mode, bit_clock_oe, frame_clock_oe}, 16'h0);
      power_down_n = 1'b1;
      cyc(10);
      check(clock_mode, clock_mode_pkg::MODE_EXT_SLAVE);
      master_select = 1'b0;
      cyc(1);
      master_select = 1'b1;
      cyc(6);
      check(clock_mode, clock_mode_pkg::MODE_EXT_MASTER);
      $display("test power down done");
      master_select = 1'b0;
      slave_run = 1'b1;
      bits_per_frame = 6'h10;
      cyc(1000);
      check(slave_bit_rate_low, 1'b1);
      bits_per_frame = 6'h20;
      cyc(1000);
      check({slave_bit_rate_low, frame_clock_oe}, 16'h0);
      $display("test slave bit rate done");
      wrap_up();
   end
endmodule

// file: bench/audio_port_partner.sv
// far-side audio port model: frame and bit clock source, master clock oscillator
// assumes the bench resolves pins; an undriven line is pulled down there
module audio_port_partner (
   input  wire logic       sys_clk,
   input  wire logic       slave_run,
   input  wire logic       mclk_run,
   input  wire logic [5:0] bits_per_frame,
   output logic            bit_drive,
   output logic            frame_drive,
   output logic            drive_en,
   output logic            mclk_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] mdiv_reg = 2'h0;
   logic [2:0] bdiv_reg = 3'h0;
   logic [5:0] bcnt_reg = 6'h0;
   assign drive_en = slave_run;
   // oscillator, period of four system clocks
   always_ff @(posedge sys_clk) begin
      mdiv_reg <= mclk_run ? mdiv_reg + 2'h1 : 2'h0;
   end
   assign mclk_drive = mdiv_reg[1];
   // bit clock of eight cycles, bits counted per frame
   always_ff @(posedge sys_clk) begin
      bdiv_reg <= slave_run ? bdiv_reg + 3'h1 : 3'h0;
      if (!slave_run) begin
         bcnt_reg <= 6'h0;
      end else if (bdiv_reg == 3'h7) begin
         bcnt_reg <= (bcnt_reg == bits_per_frame - 6'h1) ? 6'h0 : bcnt_reg + 6'h1;
      end
   end
   assign bit_drive   = bdiv_reg[2];
   assign frame_drive = bcnt_reg < (bits_per_frame >> 1);
endmodule

// file: core/audio_clock_mode_control.sv
// clock mode selection, pin direction and clock generation for the audio port
// assumes control bits come from logic on sys_clk; pins are asynchronous
module audio_clock_mode_control #(
   parameter int LOCK_FRAME_CYC     = clock_mode_pkg::LOCK_FRAME_CYC,
   parameter int LOCK_BIT_CYC       = clock_mode_pkg::LOCK_BIT_CYC,
   parameter int LOCK_MASTER_CLOCK_IN_CYC      = clock_mode_pkg::LOCK_MASTER_CLOCK_IN_CYC,
   parameter int LOCK_MASTER_CLOCK_IN_SLOW_CYC = clock_mode_pkg::LOCK_MASTER_CLOCK_IN_SLOW_CYC,
   parameter int TICK_DIV           = clock_mode_pkg::TICK_DIV_DEF
) (
   input  wire logic                      sys_clk,
   input  wire logic                      srst,
   input  wire logic                      power_down_n,
   input  wire logic                      pll_power_enable,
   input  wire logic                      master_select,
   input  wire logic                      aux_input3_select,
   input  wire logic [3:0]                pll_ref_select,
   input  wire logic [3:0]                rate_select,
   input  wire logic                      bit_clock_rate_select,
   input  wire logic [1:0]                mclk_out_divider,
   input  wire logic                      master_clock_out_enable,
   input  wire logic                      master_clock_in,
   input  wire logic                      bit_clock_in,
   input  wire logic                      frame_clock_in,
   output logic                           bit_clock_out,
   output logic                           bit_clock_oe,
   output logic                           frame_clock_out,
   output logic                           frame_clock_oe,
   output logic                           master_clock_out,
   output clock_mode_pkg::clock_mode_t    clock_mode,
   output logic                           pll_locked,
   output logic                           pll_ref_invalid,
   output logic                           slave_bit_rate_low
);
   localparam int CW = clock_mode_pkg::LOCK_CNT_W;
   if (TICK_DIV < 1 || TICK_DIV > 255) $error("tick divider out of range");
   if (LOCK_FRAME_CYC < 1 || LOCK_FRAME_CYC >= 2 ** CW) $error("lock count too wide");
   if (LOCK_MASTER_CLOCK_IN_SLOW_CYC < 1 || LOCK_MASTER_CLOCK_IN_SLOW_CYC >= 2 ** CW) $error("lock count too wide");
   if (LOCK_BIT_CYC < 1 || LOCK_MASTER_CLOCK_IN_CYC < 1) $error("lock count too small");
   // pin synchronisers, a level counts once stages two and three agree
   logic [3:0] pin_raw;
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic [3:0] pin_s3_reg;
   logic [3:0] pin_reg;
   logic [3:0] pin_d_reg;
   assign pin_raw = {power_down_n, frame_clock_in, bit_clock_in, master_clock_in};
   always_ff @(posedge sys_clk) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_reg   <= 4'h0;
         pin_d_reg <= 4'h0;
      end else begin
         pin_reg   <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
         pin_d_reg <= pin_reg;
      end
   end
   logic pdn_low;
   logic master_clock_in_rise;
   logic bit_rise;
   logic frame_rise;
   assign pdn_low    = ~pin_reg[clock_mode_pkg::PIN_PDN];
   assign master_clock_in_rise  = pin_reg[clock_mode_pkg::PIN_MASTER_CLOCK_IN] & ~pin_d_reg[clock_mode_pkg::PIN_MASTER_CLOCK_IN];
   assign bit_rise   = pin_reg[clock_mode_pkg::PIN_BIT] & ~pin_d_reg[clock_mode_pkg::PIN_BIT];
   assign frame_rise = pin_reg[clock_mode_pkg::PIN_FRAME] & ~pin_d_reg[clock_mode_pkg::PIN_FRAME];
   // master/slave select, blocked until a fresh write after reset or power-down
   logic ms_reg;
   logic ms_block_reg;
   always_ff @(posedge sys_clk) begin
      if (srst || pdn_low) begin
         ms_reg       <= 1'b0;
         ms_block_reg <= 1'b1;
      end else begin
         ms_reg       <= master_select & ~ms_block_reg;
         ms_block_reg <= ms_block_reg & master_select;
      end
   end
   // mode decode
   logic                        pll_on;
   clock_mode_pkg::clock_mode_t mode_next;
   clock_mode_pkg::clock_mode_t mode_reg;
   assign pll_on = pll_power_enable & ~aux_input3_select;
   always_comb begin
      case ({pll_on, ms_reg})
         2'b11:   mode_next = clock_mode_pkg::MODE_PLL_MASTER;
         2'b10:   mode_next = clock_mode_pkg::MODE_PLL_SLAVE;
         2'b01:   mode_next = clock_mode_pkg::MODE_EXT_MASTER;
         default: mode_next = clock_mode_pkg::MODE_EXT_SLAVE;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_reg <= clock_mode_pkg::MODE_EXT_SLAVE;
      end else begin
         mode_reg <= mode_next;
      end
   end
   // reference decode and lock time
   logic          ref_valid;
   logic [CW-1:0] lock_load;
   always_comb begin
      ref_valid = (pll_ref_select == clock_mode_pkg::REF_FRAME)
                | (pll_ref_select == clock_mode_pkg::REF_BIT32)
                | (pll_ref_select == clock_mode_pkg::REF_BIT64)
                | ((pll_ref_select >= clock_mode_pkg::REF_MASTER_CLOCK_IN_LO)
                   && (pll_ref_select <= clock_mode_pkg::REF_MASTER_CLOCK_IN_HI))
                | (pll_ref_select >= clock_mode_pkg::REF_MCKI2_LO);
      if (pll_ref_select == clock_mode_pkg::REF_FRAME) begin
         lock_load = CW'(LOCK_FRAME_CYC);
      end else if (pll_ref_select == clock_mode_pkg::REF_BIT32
                   || pll_ref_select == clock_mode_pkg::REF_BIT64) begin
         lock_load = CW'(LOCK_BIT_CYC);
      end else if (pll_ref_select >= clock_mode_pkg::REF_MASTER_CLOCK_IN_SLOW) begin
         lock_load = CW'(LOCK_MASTER_CLOCK_IN_SLOW_CYC);
      end else begin
         lock_load = CW'(LOCK_MASTER_CLOCK_IN_CYC);
      end
   end
   // lock timer, restarted at power-up and at a rate change
   logic          pll_on_d_reg;
   logic [3:0]    rate_d_reg;
   logic [CW-1:0] lock_cnt_reg;
   logic          hold_low_reg;
   logic          pll_start;
   logic          pll_restart;
   logic          lock_now;
   assign pll_start   = pll_on & ~pll_on_d_reg;
   assign pll_restart = pll_start | (pll_on & (rate_select != rate_d_reg));
   assign lock_now    = pll_on & ~pll_restart & (lock_cnt_reg == '0) & ref_valid;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pll_on_d_reg <= 1'b0;
         rate_d_reg   <= 4'h0;
         lock_cnt_reg <= '0;
      end else begin
         pll_on_d_reg <= pll_on;
         rate_d_reg   <= rate_select;
         if (pll_restart) begin
            lock_cnt_reg <= lock_load;
         end else if (lock_cnt_reg != '0) begin
            lock_cnt_reg <= lock_cnt_reg - CW'(1);
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst || !pll_on) begin
         hold_low_reg <= 1'b0;
      end else if (pll_start) begin
         hold_low_reg <= 1'b1;
      end else if (lock_now) begin
         hold_low_reg <= 1'b0;
      end
   end
   // clock phase accumulator: 1024 counts per frame
   logic [7:0] tick_cnt_reg;
   logic       tick;
   logic [9:0] inc;
   logic [9:0] acc_reg;
   assign tick = (tick_cnt_reg == 8'(TICK_DIV - 1));

   always_comb begin
      case (rate_select[1:0])
         2'h0:    inc = clock_mode_pkg::INC_EXT_256;
         2'h1:    inc = clock_mode_pkg::INC_EXT_512;
         default: inc = clock_mode_pkg::INC_EXT_1024;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst || tick) begin
         tick_cnt_reg <= 8'h00;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         acc_reg <= 10'h000;
      end else if (pll_on) begin
         if (tick) begin
            acc_reg <= acc_reg + clock_mode_pkg::INC_PLL;
         end
      end else if (master_clock_in_rise) begin
         acc_reg <= acc_reg + inc;
      end
   end

   logic is_master;
   logic is_pll_master;
   logic bit_sel;
   logic mclk_sel;
   assign is_master     = (mode_reg == clock_mode_pkg::MODE_PLL_MASTER)
                        | (mode_reg == clock_mode_pkg::MODE_EXT_MASTER);
   assign is_pll_master = (mode_reg == clock_mode_pkg::MODE_PLL_MASTER);
   assign bit_sel       = bit_clock_rate_select ? acc_reg[clock_mode_pkg::ACC_64FS_BIT]
                                                : acc_reg[clock_mode_pkg::ACC_32FS_BIT];
   assign mclk_sel      = acc_reg[clock_mode_pkg::ACC_256FS_BIT + int'(mclk_out_divider)];
   // pin drivers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bit_clock_out    <= 1'b0;
         bit_clock_oe     <= 1'b0;
         frame_clock_out  <= 1'b0;
         frame_clock_oe   <= 1'b0;
         master_clock_out <= 1'b0;
      end else begin
         bit_clock_oe     <= is_master;
         frame_clock_oe   <= is_master;
         bit_clock_out    <= is_master & ~(is_pll_master & hold_low_reg)
                             & bit_sel;
         frame_clock_out  <= is_master & ~(is_pll_master & hold_low_reg)
                             & acc_reg[clock_mode_pkg::ACC_FRAME_BIT];
         master_clock_out <= master_clock_out_enable & pll_on
                             & mclk_sel;
      end
   end
   // status
   logic [5:0] bit_cnt_reg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pll_locked         <= 1'b0;
         pll_ref_invalid    <= 1'b0;
         clock_mode         <= clock_mode_pkg::MODE_EXT_SLAVE;
         bit_cnt_reg        <= 6'h00;
         slave_bit_rate_low <= 1'b0;
      end else begin
         pll_locked      <= lock_now;
         pll_ref_invalid <= pll_on & ~ref_valid;
         clock_mode      <= mode_reg;
         if (is_master) begin
            bit_cnt_reg        <= 6'h00;
            slave_bit_rate_low <= 1'b0;
         end else if (frame_rise) begin
            slave_bit_rate_low <= (bit_cnt_reg < clock_mode_pkg::MIN_BITS_FRAME);
            bit_cnt_reg        <= 6'h00;
         end else if (bit_rise && bit_cnt_reg != 6'h3F) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
      end
   end
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence pll_power_up_s;
      !pll_on ##1 pll_on;
   endsequence
   mode_decode_a: assert property (
      $past(ms_reg) && $past(pll_on) |-> mode_reg == clock_mode_pkg::MODE_PLL_MASTER)
      else $error("pll master mode not entered");
   ext_master_a: assert property (
      $past(ms_reg) && !$past(pll_on) |-> mode_reg == clock_mode_pkg::MODE_EXT_MASTER)
      else $error("external master mode not entered");
   pdn_slave_a: assert property (pdn_low |=> !ms_reg ##1 !is_master)
      else $error("power-down did not force slave");
   pins_float_a: assert property (!ms_reg |=> ##1 !bit_clock_oe && !frame_clock_oe)
      else $error("clock pins driven in slave");
   mclk_low_a: assert property (!master_clock_out_enable |=> !master_clock_out)
      else $error("master clock out not low");
   ext_no_mclk_a: assert property (!pll_on |=> !master_clock_out)
      else $error("master clock out in external mode");
   aux_block_a: assert property (aux_input3_select |=> !mode_reg[0])
      else $error("pll mode with aux input selected");
   lock_load_a: assert property (
      pll_power_up_s |=> lock_cnt_reg == $past(lock_load))
      else $error("lock timer not loaded");
   hold_low_a: assert property (
      is_pll_master && hold_low_reg |=> !bit_clock_out && !frame_clock_out)
      else $error("clocks not held low before lock");
   bad_ref_a: assert property (
      pll_on && pll_ref_select == 4'h1 |=> pll_ref_invalid && !pll_locked)
      else $error("unavailable reference accepted");
endmodule

// file: core/clock_mode_pkg.sv
// constants and types for the audio clock mode controller
// assumes a 200 MHz system clock; pin levels arrive unsynchronised
package clock_mode_pkg;
   typedef enum logic [1:0] {
      MODE_EXT_SLAVE  = 2'h0,
      MODE_PLL_SLAVE  = 2'h1,
      MODE_PLL_MASTER = 2'h3,
      MODE_EXT_MASTER = 2'h2
   } clock_mode_t;

   localparam int          CLK_MHZ          = 200;
   localparam int          LOCK_FRAME_MS    = 160;
   localparam int          LOCK_BIT_MS      = 4;
   localparam int          LOCK_MASTER_CLOCK_IN_MS     = 40;
   localparam int          LOCK_MASTER_CLOCK_IN_SLOW_MS = 60;
   localparam int          LOCK_FRAME_CYC   = LOCK_FRAME_MS * 1000 * CLK_MHZ;
   localparam int          LOCK_BIT_CYC     = LOCK_BIT_MS * 1000 * CLK_MHZ;
   localparam int          LOCK_MASTER_CLOCK_IN_CYC    = LOCK_MASTER_CLOCK_IN_MS * 1000 * CLK_MHZ;
   localparam int          LOCK_MASTER_CLOCK_IN_SLOW_CYC = LOCK_MASTER_CLOCK_IN_SLOW_MS * 1000 * CLK_MHZ;
   localparam int          LOCK_CNT_W       = 26;
   localparam int          TICK_DIV_DEF     = 4;

   localparam logic [3:0]  REF_FRAME        = 4'h0;
   localparam logic [3:0]  REF_BIT32        = 4'h2;
   localparam logic [3:0]  REF_BIT64        = 4'h3;
   localparam logic [3:0]  REF_MASTER_CLOCK_IN_LO      = 4'h4;
   localparam logic [3:0]  REF_MASTER_CLOCK_IN_HI      = 4'h8;
   localparam logic [3:0]  REF_MCKI2_LO     = 4'hC;
   localparam logic [3:0]  REF_MASTER_CLOCK_IN_SLOW    = 4'hE;

   localparam logic [9:0]  INC_PLL          = 10'h002;
   localparam logic [9:0]  INC_EXT_256      = 10'h004;
   localparam logic [9:0]  INC_EXT_512      = 10'h002;
   localparam logic [9:0]  INC_EXT_1024     = 10'h001;
   localparam int          ACC_FRAME_BIT    = 9;
   localparam int          ACC_256FS_BIT    = 1;
   localparam int          ACC_64FS_BIT     = 3;
   localparam int          ACC_32FS_BIT     = 4;
   localparam logic [5:0]  MIN_BITS_FRAME   = 6'h20;
   localparam int          PIN_MASTER_CLOCK_IN         = 0;
   localparam int          PIN_BIT          = 1;
   localparam int          PIN_FRAME        = 2;
   localparam int          PIN_PDN          = 3;
endpackage
